// file: common/pbh_regs.svh
// Constants for the primary bus hold and control block.
`ifndef PBH_REGS_SVH
`define PBH_REGS_SVH
// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define PBH_ADDR_W 24
`define PBH_DATA_W 32
`define PBH_RESET_VECTOR 24'h000000
// ----------------------------------------
// Timing
// ----------------------------------------
`define PBH_CLOCK_MHZ 40
`define PBH_BUS_CLK_DIV 2
`endif

// file: common/pbh_pkg.sv
// Types for the primary bus hold and control block.
package pbh_pkg;
	typedef enum logic [1:0] {PBH_IDLE, PBH_ACCESS, PBH_HELD} pbh_state_t;
endpackage

// file: logic/pbh_clkgen.sv
// Bus clock phase generator dividing the device clock by two.
`timescale 1ns/10ps
`include "pbh_regs.svh"
module pbh_clkgen
(
	input wire logic clock,
	input wire logic arst_n,
	output logic bus_clock_phase_a,
	output logic bus_clock_phase_b
);
	logic phase;
	logic next_phase;

	// ----------------------------------------
	// Divider
	// ----------------------------------------
	// Toggle each rising edge so the phases run at twice the input period.
	always_comb
	begin
		next_phase = ~phase; // [RULE_14]
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			phase <= 1'b0;
		else
			phase <= next_phase;
	end

	// The two phases are complementary, as the bus timing expects.
	assign bus_clock_phase_a = phase;
	assign bus_clock_phase_b = ~phase;
endmodule

// file: logic/pbh_bus_ctrl.sv
// Primary bus controller with hold handshake, reset, acknowledge and float.
//
// Function
// [RULE_01] Read/write high on reads, low on writes.
// [RULE_02] External device signals ready to complete access.
// [RULE_03] Finish ongoing transaction before granting hold.
// [RULE_04] Float bus and start nothing while held.
// [RULE_05] Hold lasts until request high or disable.
// [RULE_06] Acknowledge low only once bus floats.
// [RULE_07] Acknowledge high on request high or disable.
// [RULE_08] Stay in reset while reset is low.
// [RULE_09] After reset, begin at the reset vector.
// [RULE_10] Pulse acknowledge output only on instruction.
// [RULE_11] Shutdown low floats every pin, stops operation.
// [RULE_12] Shutdown leaves internal state undefined.
// [RULE_13] System resets with shutdown high afterwards.
// [RULE_14] Two bus clocks at twice input period.
// [RULE_15] 24-bit address, 32-bit bidirectional data.
// [RULE_16] Strobe extends with wait states until ready.
`timescale 1ns/10ps
`include "pbh_regs.svh"
module pbh_bus_ctrl
#(
	parameter int ADDR_W = `PBH_ADDR_W,
	parameter int DATA_W = `PBH_DATA_W,
	parameter logic [ADDR_W-1:0] RESET_VECTOR = `PBH_RESET_VECTOR
)
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic shutdown_float_n,
	input wire logic hold_req_n,
	input wire logic hold_disable_bit,
	input wire logic ready_n,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_wdata,
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_rdata,
	input wire logic ack_instr,
	output logic [ADDR_W-1:0] start_pc,
	output logic start_pc_valid,
	output logic [ADDR_W-1:0] address_port_o,
	output logic address_port_oe,
	input wire logic [DATA_W-1:0] data_port_i,
	output logic [DATA_W-1:0] data_port_o,
	output logic data_port_oe,
	output logic access_strobe_n_o,
	output logic access_strobe_oe,
	output logic read_write_o,
	output logic read_write_oe,
	output logic bus_grant_ack_n_o,
	output logic bus_grant_ack_n_oe,
	output logic int_ack_out_n_o,
	output logic int_ack_out_n_oe,
	output logic bus_clock_phase_a_o,
	output logic bus_clock_phase_a_oe,
	output logic bus_clock_phase_b_o,
	output logic bus_clock_phase_b_oe
);
	pbh_pkg::pbh_state_t state;
	pbh_pkg::pbh_state_t next_state;
	logic [ADDR_W-1:0] addr;
	logic [ADDR_W-1:0] next_addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] next_wdata;
	logic [DATA_W-1:0] next_rdata;
	logic write;
	logic next_write;
	logic ack_n;
	logic next_ack_n;
	logic int_ack_out_n;
	logic next_int_ack_out_n;
	logic rsp;
	logic next_rsp;
	logic started;
	logic next_started;
	logic run;
	logic hold_want;
	logic phase_a;
	logic phase_b;

	// ----------------------------------------
	// Bus clock phases
	// ----------------------------------------
	pbh_clkgen u_clkgen
	(
		.clock(clock),
		.arst_n(arst_n),
		.bus_clock_phase_a(phase_a),
		.bus_clock_phase_b(phase_b)
	);

	// Shutdown holds the state machine and bus registers, but the clock divider keeps toggling; contents are not guaranteed afterwards.
	assign run = shutdown_float_n; // [RULE_11] [RULE_12]
	// The disable bit overrides a pending request so software can reclaim the bus.
	assign hold_want = ~hold_req_n & ~hold_disable_bit; // [RULE_05]

	// ----------------------------------------
	// Transaction and hold state machine
	// ----------------------------------------
	// A request is taken only in idle, so a hold can never cut an access short.
	always_comb
	begin
		next_state = state;
		next_addr = addr;
		next_wdata = wdata;
		next_write = write;
		next_rdata = rsp_rdata;
		next_rsp = 1'b0;
		next_ack_n = ack_n;
		next_int_ack_out_n = 1'b1;
		next_started = 1'b1;
		if (run)
		begin
			next_int_ack_out_n = ~ack_instr; // [RULE_10]
			unique case (state)
				pbh_pkg::PBH_IDLE:
				begin
					if (hold_want)
						next_state = pbh_pkg::PBH_HELD; // [RULE_03]
					else if (req_valid)
					begin
						next_state = pbh_pkg::PBH_ACCESS;
						next_addr = req_addr;
						next_wdata = req_wdata;
						next_write = req_write;
					end
				end
				pbh_pkg::PBH_ACCESS:
				begin
					// Wait states are added until ready arrives.
					if (!ready_n) // [RULE_16] [RULE_02]
					begin
						next_state = pbh_pkg::PBH_IDLE;
						next_rsp = 1'b1;
						if (!write)
							next_rdata = data_port_i;
					end
				end
				pbh_pkg::PBH_HELD:
				begin
					// Acknowledge follows the floated bus by one cycle.
					next_ack_n = 1'b0; // [RULE_06]
					if (!hold_want)
					begin
						next_state = pbh_pkg::PBH_IDLE; // [RULE_05]
						next_ack_n = 1'b1; // [RULE_07]
					end
				end
				// The spare state code is never entered; recover to idle if it appears.
				default:
				begin
					next_state = pbh_pkg::PBH_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n) // [RULE_08]
		begin
			state <= pbh_pkg::PBH_IDLE;
			addr <= '0;
			wdata <= '0;
			write <= 1'b0;
			rsp_rdata <= '0;
			rsp <= 1'b0;
			ack_n <= 1'b1;
			int_ack_out_n <= 1'b1;
			started <= 1'b0;
		end
		else
		begin
			state <= next_state;
			addr <= next_addr;
			wdata <= next_wdata;
			write <= next_write;
			rsp_rdata <= next_rdata;
			rsp <= next_rsp;
			ack_n <= next_ack_n;
			int_ack_out_n <= next_int_ack_out_n;
			started <= next_started;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Start vector is offered for one cycle after reset release.
	assign start_pc = RESET_VECTOR; // [RULE_09]
	assign start_pc_valid = arst_n & ~started & run; // [RULE_09]
	assign req_ready = run & (state == pbh_pkg::PBH_IDLE) & ~hold_want; // [RULE_04]
	assign rsp_valid = rsp;

	// Bus pins float when held or shut down; reset also floats address and data.
	assign address_port_o = addr; // [RULE_15]
	assign address_port_oe = run & arst_n & (state != pbh_pkg::PBH_HELD); // [RULE_04]
	assign read_write_o = ~write; // [RULE_01]
	assign read_write_oe = address_port_oe;
	assign data_port_o = wdata; // [RULE_15]
	assign data_port_oe = address_port_oe & (state == pbh_pkg::PBH_ACCESS) & write;
	assign access_strobe_n_o = ~(state == pbh_pkg::PBH_ACCESS); // [RULE_16]
	assign access_strobe_oe = run & (state != pbh_pkg::PBH_HELD); // [RULE_04]
	assign bus_grant_ack_n_o = ack_n;
	assign bus_grant_ack_n_oe = run; // [RULE_11]
	assign int_ack_out_n_o = int_ack_out_n;
	assign int_ack_out_n_oe = run;
	assign bus_clock_phase_a_o = phase_a; // [RULE_14]
	assign bus_clock_phase_a_oe = run;
	assign bus_clock_phase_b_o = phase_b;
	assign bus_clock_phase_b_oe = run;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_hold_entry;
		hold_want && state == pbh_pkg::PBH_IDLE && run;
	endsequence

	sequence s_floated_then_ack;
		(!address_port_oe && !access_strobe_oe) ##1 !bus_grant_ack_n_o;
	endsequence

	a_ack_after_float: assert property (@(posedge clock) disable iff (!arst_n)
		s_hold_entry ##1 hold_want && run |-> s_floated_then_ack) // [RULE_06]
		else $error("Grant acknowledge did not follow floated bus.");
	a_ack_needs_float: assert property (@(posedge clock) disable iff (!arst_n)
		!bus_grant_ack_n_o |-> !address_port_oe && !data_port_oe && !read_write_oe
		&& !access_strobe_oe) // [RULE_04]
		else $error("Acknowledge low while bus driven.");
	a_ack_release: assert property (@(posedge clock) disable iff (!arst_n)
		!bus_grant_ack_n_o && !hold_want && run |=> bus_grant_ack_n_o) // [RULE_07]
		else $error("Acknowledge not released.");
	a_access_finish: assert property (@(posedge clock) disable iff (!arst_n)
		state == pbh_pkg::PBH_ACCESS && ready_n && run |=> state == pbh_pkg::PBH_ACCESS) // [RULE_03]
		else $error("Access left before ready.");
	a_strobe_ready: assert property (@(posedge clock) disable iff (!arst_n)
		!access_strobe_n_o && !ready_n && run |=> access_strobe_n_o && rsp_valid) // [RULE_16]
		else $error("Strobe did not end on ready.");
	// The level is judged against the request that was taken, not the internal copy.
	a_rw_level: assert property (@(posedge clock) disable iff (!arst_n)
		req_valid && req_ready ##1 run |-> !access_strobe_n_o
		&& read_write_o == !$past(req_write) && data_port_oe == $past(req_write)) // [RULE_01]
		else $error("Read/write level wrong.");
	a_shutdown_float: assert property (@(posedge clock) disable iff (!arst_n)
		!shutdown_float_n |-> !address_port_oe && !access_strobe_oe && !bus_grant_ack_n_oe
		&& !int_ack_out_n_oe && !bus_clock_phase_a_oe && !bus_clock_phase_b_oe
		&& !data_port_oe && !read_write_oe) // [RULE_11]
		else $error("Pin driven during shutdown.");
	a_int_ack_out_pulse: assert property (@(posedge clock) disable iff (!arst_n)
		$fell(int_ack_out_n_o) |-> $past(ack_instr) && $past(run)) // [RULE_10]
		else $error("Acknowledge pulse without instruction.");
	a_phase_toggle: assert property (@(posedge clock) disable iff (!arst_n)
		$past(arst_n) |-> bus_clock_phase_a_o != $past(bus_clock_phase_a_o)) // [RULE_14]
		else $error("Bus clock phase did not toggle.");
endmodule

// file: verif/pbh_mem_model.sv
// Behavioural external memory on the primary bus, with a set count of wait states.
`timescale 1ns/10ps
module pbh_mem_model
(
	input wire logic clock,
	input wire logic access_strobe_n_o,
	input wire logic read_write_o,
	input wire logic [23:0] address_port_o,
	input wire logic [31:0] data_port_o,
	input wire logic [3:0] wait_cycles,
	output logic ready_n,
	output logic [31:0] mem_rdata
);
	logic [31:0] mem [16];
	logic [31:0] last = 32'h00000000;
	logic [3:0] cnt = 4'h0;
	// Off a read the lines show the inverse of the last word, so stale data never matches.
	assign ready_n = !(access_strobe_n_o === 1'b0 && cnt == wait_cycles);
	assign mem_rdata = (!access_strobe_n_o && read_write_o) ? mem[address_port_o[3:0]] : ~last;
	// Strobe cycles are counted and a write is stored on its completing edge.
	always @(posedge clock)
	begin
		cnt <= (access_strobe_n_o || !ready_n) ? 4'h0 : cnt + 4'h1;
		if (!ready_n && !read_write_o)
			mem[address_port_o[3:0]] <= data_port_o;
		if (!ready_n)
			last <= mem_rdata;
	end
endmodule

// file: verif/primary_bus_hold_and_control_test.sv
// Self-checking bench for the primary bus controller.
`timescale 1ns/10ps
module primary_bus_hold_and_control_test;
	logic clock = 1'b0, arst_n = 1'b0, shutdown_float_n = 1'b1, hold_req_n = 1'b1;
	logic hold_disable_bit = 1'b0, ready_n, req_valid = 1'b0, req_ready, req_write = 1'b0;
	logic rsp_valid, start_pc_valid, ack_instr = 1'b0, address_port_oe, data_port_oe;
	logic access_strobe_n_o, access_strobe_oe, read_write_o, read_write_oe;
	logic bus_grant_ack_n_o, bus_grant_ack_n_oe, int_ack_out_n_o, int_ack_out_n_oe;
	logic bus_clock_phase_a_o, bus_clock_phase_a_oe, bus_clock_phase_b_o, bus_clock_phase_b_oe;
	logic [23:0] req_addr = 24'h000000, start_pc, address_port_o;
	logic [31:0] req_wdata = 32'h00000000, rsp_rdata, data_port_i, data_port_o, mem_rdata, q;
	logic [3:0] wait_cycles = 4'h0;
	int miscompares = 0, checked = 0, cycles = 0;
	localparam logic [23:0] VEC = 24'h00a5c3;
	// The data wire carries whichever side is driving it.
	assign data_port_i = data_port_oe ? data_port_o : mem_rdata;
	// A floated strobe reads as idle at the memory, so a held bus starts no access.
	logic strobe_pin;
	assign strobe_pin = access_strobe_oe ? access_strobe_n_o : 1'b1;
	pbh_bus_ctrl #(.RESET_VECTOR(VEC)) DUT
	(
		.clock(clock),
		.arst_n(arst_n),
		.shutdown_float_n(shutdown_float_n),
		.hold_req_n(hold_req_n),
		.hold_disable_bit(hold_disable_bit),
		.ready_n(ready_n),
		.req_valid(req_valid),
		.req_ready(req_ready),
		.req_write(req_write),
		.req_addr(req_addr),
		.req_wdata(req_wdata),
		.rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata),
		.ack_instr(ack_instr),
		.start_pc(start_pc),
		.start_pc_valid(start_pc_valid),
		.address_port_o(address_port_o),
		.address_port_oe(address_port_oe),
		.data_port_i(data_port_i),
		.data_port_o(data_port_o),
		.data_port_oe(data_port_oe),
		.access_strobe_n_o(access_strobe_n_o),
		.access_strobe_oe(access_strobe_oe),
		.read_write_o(read_write_o),
		.read_write_oe(read_write_oe),
		.bus_grant_ack_n_o(bus_grant_ack_n_o),
		.bus_grant_ack_n_oe(bus_grant_ack_n_oe),
		.int_ack_out_n_o(int_ack_out_n_o),
		.int_ack_out_n_oe(int_ack_out_n_oe),
		.bus_clock_phase_a_o(bus_clock_phase_a_o),
		.bus_clock_phase_a_oe(bus_clock_phase_a_oe),
		.bus_clock_phase_b_o(bus_clock_phase_b_o),
		.bus_clock_phase_b_oe(bus_clock_phase_b_oe)
	);
	pbh_mem_model mem
	(
		.clock(clock),
		.access_strobe_n_o(strobe_pin),
		.read_write_o(read_write_o),
		.address_port_o(address_port_o),
		.data_port_o(data_port_o),
		.wait_cycles(wait_cycles),
		.ready_n(ready_n),
		.mem_rdata(mem_rdata)
	);
	// Clock of 25 ns; the ceiling cuts a hang short.
	initial
	begin
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			miscompares++;
			give_verdict;
		end
	end
	task automatic give_verdict;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask
	task automatic do_reset;
		arst_n = 1'b0;
		tick(3);
		check(address_port_oe === 1'b0 && bus_grant_ack_n_o === 1'b1, "reset");
		arst_n = 1'b1;
		#1;
		check(start_pc_valid === 1'b1 && start_pc === VEC, "vector");
		tick(1);
		check(start_pc_valid === 1'b0, "vector once");
	endtask
	// One access; the request stands until the edge that takes it.
	task automatic bus(input logic w, input logic [23:0] a, input logic [31:0] d,
		input logic [3:0] ws);
		int n;
		int low;
		n = 0;
		low = 0;
		wait_cycles = ws;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		req_valid = 1'b1;
		while (req_ready !== 1'b1 && n < 60)
		begin
			tick(1);
			n++;
		end
		tick(1);
		req_valid = 1'b0;
		check(read_write_o === !w && address_port_o === a, "rw");
		check(data_port_oe === w, "data drive");
		while (rsp_valid !== 1'b1 && n < 60)
		begin
			low += (access_strobe_n_o === 1'b0);
			tick(1);
			n++;
		end
		q = rsp_rdata;
		check(rsp_valid === 1'b1, "response");
		check(low == ws + 1, "wait states");
	endtask
	task automatic t_hold;
		fork
			bus(1'b0, 24'h000003, 32'h0, 4'h4);
			begin
				tick(2);
				hold_req_n = 1'b0;
				tick(1);
				check(access_strobe_n_o === 1'b0 && bus_grant_ack_n_o === 1'b1, "finish");
			end
		join
		check(q === 32'h5a5a00ff, "held read");
		tick(2);
		check(bus_grant_ack_n_o === 1'b0 && req_ready === 1'b0, "grant");
		check({address_port_oe, data_port_oe, read_write_oe, access_strobe_oe} === 4'h0,
			"float");
		hold_disable_bit = 1'b1;
		tick(2);
		check(bus_grant_ack_n_o === 1'b1, "disable");
		hold_disable_bit = 1'b0;
		tick(3);
		check(bus_grant_ack_n_o === 1'b0, "regrant");
		hold_req_n = 1'b1;
		tick(2);
		check(bus_grant_ack_n_o === 1'b1 && req_ready === 1'b1, "release");
	endtask
	initial
	begin
		do_reset;
		check(bus_clock_phase_b_o === !bus_clock_phase_a_o, "phases");
		q[0] = bus_clock_phase_a_o;
		tick(1);
		check(bus_clock_phase_a_o === !q[0], "half rate");
		bus(1'b1, 24'h000003, 32'h5a5a00ff, 4'h3);
		bus(1'b0, 24'h000003, 32'h0, 4'h0);
		check(q === 32'h5a5a00ff, "read back");
		t_hold;
		ack_instr = 1'b1;
		tick(1);
		ack_instr = 1'b0;
		check(int_ack_out_n_o === 1'b0, "ack pulse");
		tick(1);
		check(int_ack_out_n_o === 1'b1, "ack end");
		shutdown_float_n = 1'b0;
		tick(1);
		check({address_port_oe, access_strobe_oe, bus_grant_ack_n_oe, int_ack_out_n_oe,
			bus_clock_phase_a_oe, bus_clock_phase_b_oe, data_port_oe, read_write_oe,
			req_ready} === 9'h000, "shutdown");
		shutdown_float_n = 1'b1;
		do_reset;
		bus(1'b0, 24'h000003, 32'h0, 4'h1);
		check(q === 32'h5a5a00ff, "after shutdown");
		give_verdict;
	end
endmodule
